// [wpl_pkg.sv]
`default_nettype none
// ****************************************************************
// Watchdog and power LED constants.
// ****************************************************************
package wpl_pkg;

  // Register offsets on the 8-bit configuration port.
  localparam logic [7:0] ADDR_ACT   = 8'h30;
  localparam logic [7:0] ADDR_MODE  = 8'hf5;
  localparam logic [7:0] ADDR_CNT   = 8'hf6;
  localparam logic [7:0] ADDR_CTL   = 8'hf7;
  localparam logic [7:0] ADDR_ISTAT = 8'he0;
  localparam logic [7:0] ADDR_IMASK = 8'he1;

  // Field positions.
  localparam int ACT_BIT   = 0;
  localparam int LED_HI    = 7;
  localparam int LED_LO    = 6;
  localparam int FAST_BIT  = 4;
  localparam int MIN_BIT   = 3;
  localparam int KBC_BIT   = 2;
  localparam int KEYBOARD_RESET_OUT_N_BIT = 1;
  localparam int MREL_BIT  = 7;
  localparam int KREL_BIT  = 6;
  localparam int TRIG_BIT  = 5;
  localparam int STAT_BIT  = 4;
  localparam int SEL_HI    = 3;
  localparam int IST_TOUT  = 0;
  localparam int IST_RLD   = 1;

  // Writable bits and reset values.
  localparam logic [7:0] MODE_MASK = 8'hde;
  localparam logic [7:0] CTL_MASK  = 8'hcf;
  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic [1:0] RST_IRQ   = 2'h0;
  localparam logic [3:0] SEL_SMI   = 4'h2;
  localparam logic [3:0] SEL_NONE  = 4'h0;

  // Time base: one millisecond tick from the 40 ns clock.
  localparam int CLK_PERIOD_NS = 40;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

  // Count unit lengths in millisecond ticks.
  localparam logic [15:0] UNIT_FAST_S = 16'h0001;
  localparam logic [15:0] UNIT_FAST_M = 16'h003c;
  localparam logic [15:0] UNIT_SEC    = 16'h03e8;
  localparam logic [15:0] UNIT_MIN    = 16'hea60;
  localparam logic [8:0]  HALF_SEC_MS = 9'h1f4;

  typedef enum logic [1:0] {
    LED_OFF = 2'b00,
    LED_LOW = 2'b01,
    LED_1HZ = 2'b10,
    LED_QHZ = 2'b11
  } wpl_led_t;

endpackage
`default_nettype wire

// [wpl_watchdog.sv]
`timescale 1ns/100ps
`default_nettype none

module wpl_watchdog #(
  parameter int MS_CYCLES = wpl_pkg::MS_CYCLES
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output var  logic [7:0] reg_rdata,
  input  wire logic       mouse_irq,
  input  wire logic       kbd_irq,
  input  wire logic       kbc_reset_line,
  output var  logic       timeout_out_n,
  output var  logic       keyboard_reset_out_n,
  output var  logic       system_mgmt_irq_n,
  output var  logic       timeout_irq,
  output var  logic [3:0] timeout_irq_sel,
  output var  logic       power_led_out,
  output var  logic       power_led_oe,
  output var  logic       irq
);

  localparam int MSW = $clog2(MS_CYCLES + 1);
  localparam logic [MSW-1:0] MS_LAST = MSW'(MS_CYCLES - 1);

  // ****************************************************************
  // Helper functions.
  // ****************************************************************

  // Rising edge of a level sampled against its copy one cycle old.
  function automatic logic rise(input logic now, input logic was);
    return now & ~was;
  endfunction

  // Count unit length in millisecond ticks for the fast and minute bits.
  function automatic logic [15:0] unit_len(input logic fast,
                                           input logic minute);
    logic [15:0] len;
    len = wpl_pkg::UNIT_SEC;
    unique case ({fast, minute})
      2'b00: len = wpl_pkg::UNIT_SEC;
      2'b01: len = wpl_pkg::UNIT_MIN;
      2'b10: len = wpl_pkg::UNIT_FAST_S;
      2'b11: len = wpl_pkg::UNIT_FAST_M;
    endcase
    return len;
  endfunction

  // ****************************************************************
  // State.
  // ****************************************************************

  logic [7:0]     act_reg;
  logic [7:0]     mode_reg;
  logic [7:0]     cnt_reg;
  logic [7:0]     reload_reg;
  logic [7:0]     ctl_reg;
  logic           tstat_reg;
  logic [1:0]     istat_reg;
  logic [1:0]     imask_reg;
  logic [7:0]     rdata_reg;
  logic [MSW-1:0] ms_cnt_reg;
  logic [15:0]    unit_cnt_reg;
  logic [8:0]     hs_cnt_reg;
  logic [2:0]     blink_reg;
  logic           mouse_d_reg;
  logic           kbd_d_reg;
  logic           kbc_d_reg;
  logic           led_out_reg;
  logic           led_oe_reg;

  logic           wr_act;
  logic           wr_mode;
  logic           wr_cnt;
  logic           wr_ctl;
  logic           wr_istat;
  logic           wr_imask;
  logic           active;
  logic           ms_tick;
  logic           unit_tick;
  logic           mouse_ev;
  logic           kbd_ev;
  logic           reload_ev;
  logic           kbc_ev;
  logic           force_ev;
  logic           expire;
  logic           tout_ev;
  logic           routed;
  wpl_pkg::wpl_led_t led_mode;
  logic [7:0]     rd_mux;

  // ****************************************************************
  // Address decode and event terms.
  // ****************************************************************

  // Write strobes per register.
  assign wr_act   = reg_wr && (reg_addr == wpl_pkg::ADDR_ACT);
  assign wr_mode  = reg_wr && (reg_addr == wpl_pkg::ADDR_MODE);
  assign wr_cnt   = reg_wr && (reg_addr == wpl_pkg::ADDR_CNT);
  assign wr_ctl   = reg_wr && (reg_addr == wpl_pkg::ADDR_CTL);
  assign wr_istat = reg_wr && (reg_addr == wpl_pkg::ADDR_ISTAT);
  assign wr_imask = reg_wr && (reg_addr == wpl_pkg::ADDR_IMASK);

  assign active   = act_reg[wpl_pkg::ACT_BIT];
  assign led_mode = wpl_pkg::wpl_led_t'(
                      mode_reg[wpl_pkg::LED_HI:wpl_pkg::LED_LO]);

  // Interrupt reload requests, each behind its own enable.
  assign mouse_ev = rise(mouse_irq, mouse_d_reg)
                    & ctl_reg[wpl_pkg::MREL_BIT];
  assign kbd_ev   = rise(kbd_irq, kbd_d_reg)
                    & ctl_reg[wpl_pkg::KREL_BIT];
  // A reload with nothing loaded yet would only disable, so skip it.
  assign reload_ev = active & (mouse_ev | kbd_ev)
                     & (reload_reg != 8'h00);

  // Time-out sources.
  assign kbc_ev   = active & mode_reg[wpl_pkg::KBC_BIT]
                    & rise(kbc_reset_line, kbc_d_reg);
  assign force_ev = active & wr_ctl
                    & reg_wdata[wpl_pkg::TRIG_BIT];
  assign expire   = active & unit_tick
                    & (cnt_reg == 8'h01);
  assign tout_ev  = expire | force_ev | kbc_ev;

  // ****************************************************************
  // Time base.
  // ****************************************************************

  // Free running millisecond prescaler; LED and counter share it.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt_reg <= '0;
    end else if (ms_tick) begin
      ms_cnt_reg <= '0;
    end else begin
      ms_cnt_reg <= ms_cnt_reg + 1'b1;
    end
  end

  assign ms_tick = (ms_cnt_reg == MS_LAST);

  // Unit divider. It restarts on every load so the first unit is
  // full length, give or take the one millisecond of phase. It also
  // restarts on a mode write, because a count left over from a longer
  // unit would never meet the end of a shorter one.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      unit_cnt_reg <= '0;
    end else if (wr_cnt || wr_mode || reload_ev || !active ||
                 cnt_reg == 8'h00) begin
      unit_cnt_reg <= '0;
    end else if (unit_tick) begin
      unit_cnt_reg <= '0;
    end else if (ms_tick) begin
      unit_cnt_reg <= unit_cnt_reg + 16'h0001;
    end
  end

  // The unit ends on the millisecond tick that completes its length.
  assign unit_tick = ms_tick && (cnt_reg != 8'h00) &&
                     (unit_cnt_reg ==
                      unit_len(mode_reg[wpl_pkg::FAST_BIT],
                               mode_reg[wpl_pkg::MIN_BIT])
                      - 16'h0001);

  // Half-second divider and blink counter for the LED.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hs_cnt_reg <= '0;
      blink_reg  <= '0;
    end else if (ms_tick) begin
      if (hs_cnt_reg == wpl_pkg::HALF_SEC_MS - 9'h001) begin
        hs_cnt_reg <= '0;
        blink_reg  <= blink_reg + 3'h1;
      end else begin
        hs_cnt_reg <= hs_cnt_reg + 9'h001;
      end
    end
  end

  // ****************************************************************
  // Watchdog counter.
  // ****************************************************************

  // A software write beats a reload in the same cycle; writing zero
  // stops the watchdog without touching the saved reload value.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg    <= wpl_pkg::RST_BYTE;
      reload_reg <= wpl_pkg::RST_BYTE;
    end else if (wr_cnt) begin
      cnt_reg <= reg_wdata;
      if (reg_wdata != 8'h00) begin
        reload_reg <= reg_wdata;
      end
    end else if (reload_ev) begin
      cnt_reg <= reload_reg;
    end else if (active && unit_tick) begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end

  // Edge detector history.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mouse_d_reg <= 1'b0;
      kbd_d_reg   <= 1'b0;
      kbc_d_reg   <= 1'b0;
    end else begin
      mouse_d_reg <= mouse_irq;
      kbd_d_reg   <= kbd_irq;
      kbc_d_reg   <= kbc_reset_line;
    end
  end

  // ****************************************************************
  // Configuration registers.
  // ****************************************************************

  // Plain settings; reserved bits are never stored.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      act_reg  <= wpl_pkg::RST_BYTE;
      mode_reg <= wpl_pkg::RST_BYTE;
      ctl_reg  <= wpl_pkg::RST_BYTE;
    end else begin
      if (wr_act) begin
        act_reg <= {7'h00, reg_wdata[wpl_pkg::ACT_BIT]};
      end
      if (wr_mode) begin
        mode_reg <= reg_wdata & wpl_pkg::MODE_MASK;
      end
      if (wr_ctl) begin
        ctl_reg <= reg_wdata & wpl_pkg::CTL_MASK;
      end
    end
  end

  // Time-out status. A new event wins over a software clear in the
  // same cycle, so a time-out is never lost. Writing one is ignored.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tstat_reg <= 1'b0;
    end else if (tout_ev) begin
      tstat_reg <= 1'b1;
    end else if (wr_ctl && !reg_wdata[wpl_pkg::STAT_BIT]) begin
      tstat_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Interrupt status and mask.
  // ****************************************************************

  // Sticky, cleared by writing one; the setting event wins.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      istat_reg <= wpl_pkg::RST_IRQ;
      imask_reg <= wpl_pkg::RST_IRQ;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == wpl_pkg::IST_TOUT && tout_ev) ||
            (i == wpl_pkg::IST_RLD && reload_ev)) begin
          istat_reg[i] <= 1'b1;
        end else if (wr_istat && reg_wdata[i]) begin
          istat_reg[i] <= 1'b0;
        end
      end
      if (wr_imask) begin
        imask_reg <= reg_wdata[1:0];
      end
    end
  end

  assign irq = |(istat_reg & imask_reg);

  // ****************************************************************
  // Read port.
  // ****************************************************************

  // The trigger bit always reads zero since it self-clears.
  always_comb begin
    rd_mux = 8'h00;
    unique case (reg_addr)
      wpl_pkg::ADDR_ACT:   rd_mux = act_reg;
      wpl_pkg::ADDR_MODE:  rd_mux = mode_reg;
      wpl_pkg::ADDR_CNT:   rd_mux = cnt_reg;
      wpl_pkg::ADDR_CTL:   rd_mux = {ctl_reg[7:6], 1'b0, tstat_reg,
                                     ctl_reg[3:0]};
      wpl_pkg::ADDR_ISTAT: rd_mux = {6'h00, istat_reg};
      wpl_pkg::ADDR_IMASK: rd_mux = {6'h00, imask_reg};
      default:             rd_mux = 8'h00;
    endcase
  end

  // Data stands only in the cycle after the strobe, zero otherwise.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= reg_rd ? rd_mux : 8'h00;
    end
  end

  assign reg_rdata = rdata_reg;

  // ****************************************************************
  // Pins.
  // ****************************************************************

  // Time-out level holds until software clears the status bit or the active bit.
  assign timeout_out_n = ~(active & tstat_reg);
  assign keyboard_reset_out_n =
    ~(active & tstat_reg & mode_reg[wpl_pkg::KEYBOARD_RESET_OUT_N_BIT]);

  // Routing by the select field; zero routes nowhere.
  assign timeout_irq_sel = ctl_reg[wpl_pkg::SEL_HI:0];
  assign routed = active & tstat_reg;
  assign system_mgmt_irq_n =
    ~(routed && timeout_irq_sel == wpl_pkg::SEL_SMI);
  assign timeout_irq = routed &&
                       timeout_irq_sel != wpl_pkg::SEL_SMI &&
                       timeout_irq_sel != wpl_pkg::SEL_NONE;

  // LED works whether or not the watchdog is active.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      led_out_reg <= 1'b0;
      led_oe_reg  <= 1'b0;
    end else begin
      unique case (led_mode)
        wpl_pkg::LED_OFF: begin
          led_out_reg <= 1'b0;
          led_oe_reg  <= 1'b0;
        end
        wpl_pkg::LED_LOW: begin
          led_out_reg <= 1'b0;
          led_oe_reg  <= 1'b1;
        end
        wpl_pkg::LED_1HZ: begin
          led_out_reg <= blink_reg[0];
          led_oe_reg  <= 1'b1;
        end
        wpl_pkg::LED_QHZ: begin
          led_out_reg <= blink_reg[2];
          led_oe_reg  <= 1'b1;
        end
      endcase
    end
  end

  assign power_led_out = led_out_reg;
  assign power_led_oe  = led_oe_reg;

  // ****************************************************************
  // Assertions.
  // ****************************************************************

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  property p_inactive_quiet;
    !active |-> timeout_out_n && keyboard_reset_out_n
                && system_mgmt_irq_n && !timeout_irq;
  endproperty
  a_inactive_quiet: assert property (p_inactive_quiet)
    else $error("Inactive watchdog drives an output.");

  property p_led_mode;
    ##1 (power_led_oe == ($past(led_mode) != wpl_pkg::LED_OFF)) &&
        ($past(led_mode) != wpl_pkg::LED_LOW || !power_led_out);
  endproperty
  a_led_mode: assert property (p_led_mode)
    else $error("LED pin does not follow its mode.");

  property p_fast_unit;
    active && ms_tick && cnt_reg != 8'h00 &&
    mode_reg[wpl_pkg::FAST_BIT] && !mode_reg[wpl_pkg::MIN_BIT] &&
    !wr_cnt && !reload_ev |-> unit_tick;
  endproperty
  a_fast_unit: assert property (p_fast_unit)
    else $error("Fast second mode missed a unit.");

  property p_min_unit;
    unit_tick && !mode_reg[wpl_pkg::FAST_BIT] &&
    mode_reg[wpl_pkg::MIN_BIT] |-> unit_cnt_reg == 16'hea5f;
  endproperty
  a_min_unit: assert property (p_min_unit)
    else $error("Minute unit of wrong length.");

  property p_kbc_edge;
    active && mode_reg[wpl_pkg::KBC_BIT] &&
    kbc_reset_line && !kbc_d_reg |=> tstat_reg && !timeout_out_n;
  endproperty
  a_kbc_edge: assert property (p_kbc_edge)
    else $error("Reset line edge gave no time-out.");

  property p_keyboard_reset_out_n_off;
    !mode_reg[wpl_pkg::KEYBOARD_RESET_OUT_N_BIT] |-> keyboard_reset_out_n;
  endproperty
  a_keyboard_reset_out_n_off: assert property (p_keyboard_reset_out_n_off)
    else $error("Keyboard reset pulsed while disabled.");

  property p_load;
    wr_cnt && reg_wdata != 8'h00 |=>
      cnt_reg == $past(reg_wdata) && reload_reg == $past(reg_wdata);
  endproperty
  a_load: assert property (p_load)
    else $error("Counter write not loaded.");

  property p_reload;
    reload_ev && !wr_cnt |=> cnt_reg == $past(reload_reg);
  endproperty
  a_reload: assert property (p_reload)
    else $error("Interrupt reload lost.");

  property p_read_cnt;
    reg_rd && reg_addr == wpl_pkg::ADDR_CNT |=>
      reg_rdata == $past(cnt_reg);
  endproperty
  a_read_cnt: assert property (p_read_cnt)
    else $error("Count read is not the live counter.");

  property p_zero_hold;
    cnt_reg == 8'h00 && !wr_cnt && !reload_ev |=> cnt_reg == 8'h00;
  endproperty
  a_zero_hold: assert property (p_zero_hold)
    else $error("Disabled counter moved.");

  property p_mouse_off;
    !ctl_reg[wpl_pkg::MREL_BIT] && !kbd_ev && !wr_cnt && !unit_tick
      |=> cnt_reg == $past(cnt_reg);
  endproperty
  a_mouse_off: assert property (p_mouse_off)
    else $error("Mouse interrupt moved the counter.");

  property p_force;
    active && wr_ctl && reg_wdata[wpl_pkg::TRIG_BIT] |=>
      tstat_reg ##1 (!reg_rd || !reg_rdata[wpl_pkg::TRIG_BIT]);
  endproperty
  a_force: assert property (p_force)
    else $error("Forced time-out failed.");

  property p_smi;
    active && tstat_reg && timeout_irq_sel == wpl_pkg::SEL_SMI
      |-> !system_mgmt_irq_n && !timeout_irq;
  endproperty
  a_smi: assert property (p_smi)
    else $error("Time-out not routed to management irq.");

  property p_expire;
    expire && !wr_cnt && !reload_ev |=>
      cnt_reg == 8'h00 && tstat_reg && !timeout_out_n
      ##1 cnt_reg == 8'h00;
  endproperty
  a_expire: assert property (p_expire)
    else $error("Expiry not flagged or counter kept going.");

endmodule // wpl_watchdog
`default_nettype wire

// [wpl_watchdog_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module wpl_watchdog_tb;
  // Short millisecond so that a second is ten thousand cycles.
  localparam int MSC = 10;
  logic       ref_clk;
  logic       rst_n;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       mouse_irq;
  logic       kbd_irq;
  logic       kbc_reset_line;
  logic       timeout_out_n;
  logic       keyboard_reset_out_n;
  logic       system_mgmt_irq_n;
  logic       timeout_irq;
  logic [3:0] timeout_irq_sel;
  logic       power_led_out;
  logic       power_led_oe;
  logic       irq;
  int         err_count;
  int         samples_checked;
  logic [7:0] rv;
  int         n;

  wpl_watchdog #(.MS_CYCLES(MSC)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .mouse_irq(mouse_irq), .kbd_irq(kbd_irq),
    .kbc_reset_line(kbc_reset_line), .timeout_out_n(timeout_out_n),
    .keyboard_reset_out_n(keyboard_reset_out_n),
    .system_mgmt_irq_n(system_mgmt_irq_n), .timeout_irq(timeout_irq),
    .timeout_irq_sel(timeout_irq_sel), .power_led_out(power_led_out),
    .power_led_oe(power_led_oe), .irq(irq));

  // ****************************************************************
  // Bus and compare helpers.
  // ****************************************************************
  // Free running 25 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1;
    rv = reg_rdata;
    chk(rv, exp);
  endtask

  // Packs the event pins so one compare covers them all.
  function automatic logic [7:0] pins();
    return {2'b00, timeout_out_n, keyboard_reset_out_n,
            system_mgmt_irq_n, timeout_irq, power_led_oe, irq};
  endfunction

  // Waits for the time-out pin; the first unit may end a millisecond early.
  task automatic t_unit(input logic [7:0] mode, input int cnt, input int u);
    wr(wpl_pkg::ADDR_MODE, mode);
    wr(wpl_pkg::ADDR_CNT, cnt[7:0]);
    n = 1;
    while (timeout_out_n !== 1'b0 && n < cnt * u * MSC + 4) begin
      cyc(1);
      n++;
    end
    chk({7'h0, n >= (cnt * u - 1) * MSC && timeout_out_n === 1'b0}, 8'h01);
  endtask

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic t_reset();
    rd(wpl_pkg::ADDR_ACT, 8'h00);
    rd(wpl_pkg::ADDR_MODE, 8'h00);
    rd(wpl_pkg::ADDR_CNT, 8'h00);
    rd(wpl_pkg::ADDR_CTL, 8'h00);
    rd(wpl_pkg::ADDR_ISTAT, 8'h00);
    rd(8'h55, 8'h00);
    chk(pins(), 8'h38);
  endtask

  task automatic t_count();
    wr(wpl_pkg::ADDR_ACT, 8'h01);
    wr(wpl_pkg::ADDR_CTL, 8'h02);
    wr(wpl_pkg::ADDR_IMASK, 8'h01);
    t_unit(8'h12, 3, 1);
    cyc(1);
    chk(pins(), 8'h01);
    rd(wpl_pkg::ADDR_CTL, 8'h12);
    rd(wpl_pkg::ADDR_CNT, 8'h00);
    wr(wpl_pkg::ADDR_CTL, 8'h15);
    wr(wpl_pkg::ADDR_MODE, 8'h10);
    chk(pins(), 8'h1d);
    chk({4'h0, timeout_irq_sel}, 8'h05);
    wr(wpl_pkg::ADDR_IMASK, 8'h00);
    chk({7'h0, irq}, 8'h00);
    wr(wpl_pkg::ADDR_IMASK, 8'h01);
    wr(wpl_pkg::ADDR_CTL, 8'h05);
    chk({7'h0, timeout_out_n}, 8'h01);
    wr(wpl_pkg::ADDR_ISTAT, 8'h01);
    chk({7'h0, irq}, 8'h00);
  endtask

  task automatic t_modes();
    t_unit(8'h18, 1, 60);
    wr(wpl_pkg::ADDR_CTL, 8'h05);
    t_unit(8'h00, 1, 1000);
    wr(wpl_pkg::ADDR_CTL, 8'h05);
    wr(wpl_pkg::ADDR_CNT, 8'h00);
    cyc(40);
    chk({7'h0, timeout_out_n}, 8'h01);
  endtask

  task automatic t_events();
    wr(wpl_pkg::ADDR_CTL, 8'h25);
    cyc(2);
    chk({7'h0, timeout_out_n}, 8'h00);
    rd(wpl_pkg::ADDR_CTL, 8'h15);
    wr(wpl_pkg::ADDR_CTL, 8'h05);
    kbc_reset_line <= 1'b1;
    cyc(3);
    chk({7'h0, timeout_out_n}, 8'h01);
    kbc_reset_line <= 1'b0;
    wr(wpl_pkg::ADDR_MODE, 8'h14);
    kbc_reset_line <= 1'b1;
    cyc(3);
    chk({7'h0, timeout_out_n}, 8'h00);
    kbc_reset_line <= 1'b0;
    wr(wpl_pkg::ADDR_CTL, 8'h05);
  endtask

  task automatic t_reload();
    wr(wpl_pkg::ADDR_MODE, 8'h18);
    wr(wpl_pkg::ADDR_CTL, 8'h45);
    wr(wpl_pkg::ADDR_CNT, 8'h0a);
    rd(wpl_pkg::ADDR_CNT, 8'h0a);
    cyc(1300);
    mouse_irq <= 1'b1;
    cyc(3);
    rd(wpl_pkg::ADDR_CNT, 8'h08);
    kbd_irq <= 1'b1;
    cyc(3);
    rd(wpl_pkg::ADDR_CNT, 8'h0a);
    wr(wpl_pkg::ADDR_CTL, 8'h85);
    mouse_irq <= 1'b0;
    kbd_irq   <= 1'b0;
    cyc(1300);
    kbd_irq <= 1'b1;
    cyc(3);
    rd(wpl_pkg::ADDR_CNT, 8'h08);
    mouse_irq <= 1'b1;
    cyc(3);
    rd(wpl_pkg::ADDR_CNT, 8'h0a);
    wr(wpl_pkg::ADDR_CNT, 8'h00);
    wr(wpl_pkg::ADDR_ACT, 8'h00);
    wr(wpl_pkg::ADDR_CTL, 8'h25);
    wr(wpl_pkg::ADDR_MODE, 8'h10);
    wr(wpl_pkg::ADDR_CNT, 8'h01);
    cyc(3 * MSC);
    chk({7'h0, timeout_out_n}, 8'h01);
  endtask

  // Measures one blink half period. The mode switch itself may move the
  // pin, and the next toggle may then be partial, so the third is timed.
  task automatic t_blink(input logic [7:0] mode, input int hp);
    wr(wpl_pkg::ADDR_MODE, mode);
    for (int k = 0; k < 3; k++) begin
      rv[0] = power_led_out;
      n = 0;
      while (power_led_out === rv[0] && n < hp * MSC + 4) begin
        cyc(1);
        n++;
      end
    end
    chk({7'h0, n >= hp * MSC - 2 && n <= hp * MSC + 2}, 8'h01);
  endtask

  task automatic t_led();
    wr(wpl_pkg::ADDR_MODE, 8'h00);
    cyc(1);
    chk({6'h0, power_led_oe, power_led_out}, 8'h00);
    wr(wpl_pkg::ADDR_MODE, 8'h40);
    cyc(1);
    chk({6'h0, power_led_oe, power_led_out}, 8'h02);
    t_blink(8'h80, 500);
    t_blink(8'hc0, 2000);
  endtask

  // ****************************************************************
  // Verdict, watchdog and main sequence.
  // ****************************************************************
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Cuts a hang short beyond the longest expected run of about 80k cycles.
  initial begin
    #(40 * 95000);
    err_count++;
    tally_and_finish();
  end

  // Reset for sixteen cycles, then every scenario in turn.
  initial begin
    err_count       = 0;
    samples_checked = 0;
    rst_n           = 1'b0;
    reg_addr        = 8'h00;
    reg_wdata       = 8'h00;
    reg_wr          = 1'b0;
    reg_rd          = 1'b0;
    mouse_irq       = 1'b0;
    kbd_irq         = 1'b0;
    kbc_reset_line  = 1'b0;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_count();
    t_modes();
    t_events();
    t_reload();
    t_led();
    tally_and_finish();
  end
endmodule // wpl_watchdog_tb
`default_nettype wire
